/* inc/lsd_defs.svh */
// Constants for the line-state duration timer block: offsets, fields, resets, timing
`ifndef LSD_DEFS_SVH
`define LSD_DEFS_SVH

// Control bus register offsets
`define LSD_ADDR_NOISE_CNT      5'h0F
`define LSD_ADDR_NOISE_PRE      5'h10
`define LSD_ADDR_STATE_THR      5'h11
`define LSD_ADDR_STATE_PRE_THR  5'h12
`define LSD_ADDR_STATE_CNT      5'h13
`define LSD_ADDR_STATE_PRE      5'h14

// Field layout
`define LSD_CNT_W               7
`define LSD_PRE_W               8
`define LSD_DETECT_BIT          7

// Reset values
`define LSD_STATE_THR_RST       7'h00
`define LSD_STATE_PRE_THR_RST   8'h00
`define LSD_CNT_RST             7'h00
`define LSD_PRE_RST             8'h00
`define LSD_RDATA_RST           8'h00

// Timing: symbol tick period and clock period in ns
`define LSD_TICK_NS             80
`define LSD_CLK_NS              50
`define LSD_ACC_W               7

`endif

/* inc/lsd_pkg.sv */
// Types shared by the line-state duration timer block
`include "lsd_defs.svh"
package lsd_pkg;

    // Line state as reported by the line state detector
    typedef enum logic [2:0] {
        LS_ACTIVE,
        LS_NOISE,
        LS_UNKNOWN,
        LS_HALT,
        LS_IDLE,
        LS_MASTER,
        LS_QUIET,
        LS_NOSIG
    } lsd_line_type;

    // Whole state of the timer core
    typedef struct packed {
        lsd_line_type                ls_prev;
        logic [`LSD_CNT_W-1:0]       st_thr;
        logic [`LSD_PRE_W-1:0]       sp_thr;
        logic [`LSD_CNT_W-1:0]       st_cnt;
        logic [`LSD_PRE_W-1:0]       sp_cnt;
        logic [`LSD_CNT_W-1:0]       ns_cnt;
        logic [`LSD_PRE_W-1:0]       np_cnt;
        logic                        st_detect;
        logic                        ns_detect;
        logic [7:0]                  rdata;
        logic                        ack;
        logic                        rej;
        logic                        st_evt;
        logic                        st_int;
        logic                        ns_evt;
    } lsd_core_type;

    // Whole state of the symbol tick divider
    typedef struct packed {
        logic [`LSD_ACC_W-1:0]       acc;
        logic                        tick;
    } lsd_tick_type;

endpackage : lsd_pkg

/* verilog/lsd_tick.sv */
// Fractional divider making the 80 ns symbol tick from the 50 ns clock
`timescale 1ns/10ps
`include "lsd_defs.svh"
module lsd_tick
    import lsd_pkg::*;
(
    input  wire logic mclk,  // System clock
    input  wire logic nrst,  // Asynchronous reset, active low
    output wire logic tick   // One-cycle symbol tick enable
);

    lsd_tick_type s;
    lsd_tick_type next_s;

    // Phase accumulator: 80 is not a multiple of 50, so ticks come on an
    // uneven 2,2,1,2,1 cycle pattern that averages exactly 80 ns
    always_comb begin
        logic [`LSD_ACC_W:0] sum;
        sum         = {1'b0, s.acc} + (`LSD_ACC_W+1)'(`LSD_CLK_NS);
        next_s.tick = 1'b0;
        next_s.acc  = sum[`LSD_ACC_W-1:0];
        if (sum >= (`LSD_ACC_W+1)'(`LSD_TICK_NS)) begin
            next_s.acc  = `LSD_ACC_W'(sum - (`LSD_ACC_W+1)'(`LSD_TICK_NS));
            next_s.tick = 1'b1;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

endmodule : lsd_tick

/* verilog/lsd_timers.sv */
// Line-state duration timers and noise timer with control bus readback
// Notes on behaviour
// - Noise count read returns live snapshot
// - Writes to count readbacks rejected, flagged
// - Noise readback: count D0-D6, detect D7
// - Noise prescale readback returns 8-bit snapshot
// - State timer decrements when prescaler zero, qualifying
// - Timeout equals (SPT+1)*ST+SPT ticks
// - Both zero while qualifying reloads both
// - Change into qualifying state reloads both
// - Threshold write reloads both state timers
// - Prescaler at zero reloads from threshold
// - Prescaler counts down each tick when qualifying
// - Active, noise, unknown hold state timer
// - State threshold 7 bits, D7 reads zero
// - State prescale threshold holds 8 bits
// - State count readback: count D0-D6, detect D7
// - State prescale readback returns 8-bit snapshot
// - Noise timer steps every (NPT+1) ticks
// - Noise reload: both zero, qualifying, threshold write
// - Change into noise states keeps noise counting
// - Noise counters both zero raise noise event
`timescale 1ns/10ps
`include "lsd_defs.svh"
module lsd_timers
    import lsd_pkg::*;
(
    input  wire logic                  mclk,                     // System clock, 20 MHz
    input  wire logic                  nrst,                     // Async reset, active low
    input  wire logic                  cb_sel,                   // Control bus cycle strobe
    input  wire logic                  cb_wr,                    // High write, low read
    input  wire logic [4:0]            cb_addr,                  // Register offset
    input  wire logic [7:0]            cb_wdata,                 // Write data
    output wire logic [7:0]            cb_rdata,                 // Read data, with cb_ack
    output wire logic                  cb_ack,                   // Offset decoded here
    input  wire lsd_line_type          line_state,               // Current line state
    input  wire logic [`LSD_CNT_W-1:0] noise_threshold,          // Noise start value
    input  wire logic [`LSD_PRE_W-1:0] noise_prescale_threshold, // Noise prescale start
    input  wire logic                  noise_thr_written,        // Noise threshold written
    input  wire logic                  state_threshold_mask,     // Mask for state event
    output wire logic                  write_reject_set,         // Sets write reject flag
    output wire logic                  state_threshold_event,    // Sets state threshold flag
    output wire logic                  state_threshold_int,      // Unmasked state event
    output wire logic                  noise_threshold_event     // Sets noise threshold flag
);

    lsd_core_type s;
    lsd_core_type next_s;
    logic         tick;
    logic         qual;
    logic         nclass;
    logic         chg;
    logic         rd;
    logic         wr;
    logic         ro_hit;
    logic         st_wr;

    // Symbol tick divider
    lsd_tick u_tick (
        .mclk (mclk),
        .nrst (nrst),
        .tick (tick)
    );

    // Bus and line state decode
    always_comb begin
        qual   = (line_state == LS_HALT) || (line_state == LS_IDLE) ||
                 (line_state == LS_MASTER) || (line_state == LS_QUIET) ||
                 (line_state == LS_NOSIG);
        nclass = !qual;
        chg    = (line_state != s.ls_prev);
        rd     = cb_sel && !cb_wr;
        wr     = cb_sel && cb_wr;
        ro_hit = (cb_addr == `LSD_ADDR_NOISE_CNT) || (cb_addr == `LSD_ADDR_NOISE_PRE) ||
                 (cb_addr == `LSD_ADDR_STATE_CNT) || (cb_addr == `LSD_ADDR_STATE_PRE);
        st_wr  = wr && ((cb_addr == `LSD_ADDR_STATE_THR) ||
                        (cb_addr == `LSD_ADDR_STATE_PRE_THR));
    end

    // Next state of the whole core
    always_comb begin
        next_s         = s;
        next_s.ls_prev = line_state;
        next_s.ack     = cb_sel && (ro_hit || (cb_addr == `LSD_ADDR_STATE_THR) ||
                                    (cb_addr == `LSD_ADDR_STATE_PRE_THR));
        next_s.rej     = wr && ro_hit;
        next_s.st_evt  = 1'b0;
        next_s.ns_evt  = 1'b0;
        next_s.rdata   = `LSD_RDATA_RST;

        // Threshold registers; bit 7 of the state threshold is not stored
        if (wr && (cb_addr == `LSD_ADDR_STATE_THR)) begin
            next_s.st_thr = cb_wdata[`LSD_CNT_W-1:0];
        end
        if (wr && (cb_addr == `LSD_ADDR_STATE_PRE_THR)) begin
            next_s.sp_thr = cb_wdata;
        end

        // State timer pair; a write wins over a line state change
        if (st_wr) begin
            next_s.st_cnt = next_s.st_thr;
            next_s.sp_cnt = next_s.sp_thr;
        end else if (qual && chg) begin
            next_s.st_cnt = s.st_thr;
            next_s.sp_cnt = s.sp_thr;
        end else if (tick && qual) begin
            if ((s.st_cnt == '0) && (s.sp_cnt == '0)) begin
                next_s.st_cnt = s.st_thr;
                next_s.sp_cnt = s.sp_thr;
            end else if (s.sp_cnt == '0) begin
                next_s.sp_cnt = s.sp_thr;
                next_s.st_cnt = s.st_cnt - 1'b1;
            end else begin
                next_s.sp_cnt = s.sp_cnt - 1'b1;
            end
            // Both at zero marks the end of the programmed duration
            next_s.st_evt = (next_s.st_cnt == '0) && (next_s.sp_cnt == '0);
        end
        // Non-qualifying states leave the state pair untouched except on a threshold write

        // Noise timer pair; holds its count across changes between noise states
        if (noise_thr_written || qual) begin
            next_s.ns_cnt = noise_threshold;
            next_s.np_cnt = noise_prescale_threshold;
        end else if (tick && nclass) begin
            if ((s.ns_cnt == '0) && (s.np_cnt == '0)) begin
                next_s.ns_cnt = noise_threshold;
                next_s.np_cnt = noise_prescale_threshold;
            end else if (s.np_cnt == '0) begin
                next_s.np_cnt = noise_prescale_threshold;
                next_s.ns_cnt = s.ns_cnt - 1'b1;
            end else begin
                next_s.np_cnt = s.np_cnt - 1'b1;
            end
            next_s.ns_evt = (next_s.ns_cnt == '0) && (next_s.np_cnt == '0);
        end

        next_s.st_int = next_s.st_evt && !state_threshold_mask;

        // Readback snapshots are taken in the read cycle itself
        if (rd) begin
            case (cb_addr)
                `LSD_ADDR_NOISE_CNT:     next_s.rdata = {s.ns_detect, s.ns_cnt};
                `LSD_ADDR_NOISE_PRE:     next_s.rdata = s.np_cnt;
                `LSD_ADDR_STATE_THR:     next_s.rdata = {1'b0, s.st_thr};
                `LSD_ADDR_STATE_PRE_THR: next_s.rdata = s.sp_thr;
                `LSD_ADDR_STATE_CNT:     next_s.rdata = {s.st_detect, s.st_cnt};
                `LSD_ADDR_STATE_PRE:     next_s.rdata = s.sp_cnt;
                default:                 next_s.rdata = `LSD_RDATA_RST;
            endcase
        end

        // Detect bits clear on read of their register; a change in the same
        // cycle wins, though the noise bit is set only by a change into a qualifying state
        if (rd && (cb_addr == `LSD_ADDR_STATE_CNT)) begin
            next_s.st_detect = 1'b0;
        end
        if (rd && (cb_addr == `LSD_ADDR_NOISE_CNT)) begin
            next_s.ns_detect = 1'b0;
        end
        if (chg) begin
            next_s.st_detect = 1'b1;
        end
        if (chg && qual) begin
            next_s.ns_detect = 1'b1;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s           <= '0;
            s.ls_prev   <= LS_UNKNOWN;
            s.st_thr    <= `LSD_STATE_THR_RST;
            s.sp_thr    <= `LSD_STATE_PRE_THR_RST;
            s.st_cnt    <= `LSD_CNT_RST;
            s.sp_cnt    <= `LSD_PRE_RST;
            s.ns_cnt    <= `LSD_CNT_RST;
            s.np_cnt    <= `LSD_PRE_RST;
            s.rdata     <= `LSD_RDATA_RST;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign cb_rdata              = s.rdata;
    assign cb_ack                = s.ack;
    assign write_reject_set      = s.rej;
    assign state_threshold_event = s.st_evt;
    assign state_threshold_int   = s.st_int;
    assign noise_threshold_event = s.ns_evt;

    // Checks on the logic above
    default clocking cb_clk @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    sequence s_ro_write;
        cb_sel && cb_wr && ro_hit;
    endsequence

    sequence s_reject_seen;
        write_reject_set && cb_ack;
    endsequence

    a_write_reject: assert property (s_ro_write |=> s_reject_seen)
        else $error("write to a readback register was not rejected");

    a_ro_unchanged: assert property (cb_sel && cb_wr && ro_hit && !st_wr
        |=> $stable(s.st_thr) && $stable(s.sp_thr))
        else $error("rejected write changed a threshold");

    a_noise_snap: assert property (cb_sel && !cb_wr && cb_addr == `LSD_ADDR_NOISE_CNT
        |=> cb_ack && cb_rdata == {$past(s.ns_detect), $past(s.ns_cnt)})
        else $error("noise count readback wrong");

    a_state_snap: assert property (cb_sel && !cb_wr && cb_addr == `LSD_ADDR_STATE_PRE
        |=> cb_rdata == $past(s.sp_cnt))
        else $error("state prescale readback wrong");

    a_thr_reserved: assert property (cb_sel && !cb_wr && cb_addr == `LSD_ADDR_STATE_THR
        |=> cb_rdata[`LSD_DETECT_BIT] == 1'b0)
        else $error("state threshold bit 7 read as one");

    a_thr_reload: assert property (cb_sel && cb_wr && cb_addr == `LSD_ADDR_STATE_THR
        |=> s.st_cnt == $past(cb_wdata[`LSD_CNT_W-1:0]) && s.sp_cnt == s.sp_thr)
        else $error("state threshold write did not reload timers");

    a_change_reload: assert property (qual && chg && !st_wr
        |=> s.st_cnt == s.st_thr && s.sp_cnt == s.sp_thr)
        else $error("change into qualifying state did not reload");

    a_state_dec: assert property (tick && qual && !chg && !st_wr && s.sp_cnt == '0
        && s.st_cnt != '0 |=> s.st_cnt == $past(s.st_cnt) - 1'b1
        && s.sp_cnt == s.sp_thr)
        else $error("state timer step wrong");

    a_state_hold: assert property (nclass && !st_wr |=> $stable(s.st_cnt))
        else $error("state timer moved in non-qualifying state");

    a_noise_reload: assert property (qual && !noise_thr_written
        |=> s.ns_cnt == $past(noise_threshold))
        else $error("noise timer not reloaded in qualifying state");

    a_noise_event: assert property (tick && nclass && !noise_thr_written
        && s.ns_cnt == '0 && s.np_cnt == 8'h01 |=> noise_threshold_event)
        else $error("noise timeout not reported");

    a_state_event: assert property (state_threshold_event
        |-> s.st_cnt == '0 && s.sp_cnt == '0
        && (state_threshold_int == !$past(state_threshold_mask)))
        else $error("state event without timeout");

    a_detect_set: assert property (chg |=> s.st_detect)
        else $error("state change detect bit lost");

endmodule : lsd_timers

/* verification/lsd_host.sv */
// Control bus master standing in for the station management processor
`timescale 1ns/10ps
module lsd_host (
    input  wire logic       mclk,     // System clock
    output logic            cb_sel,   // Cycle strobe
    output logic            cb_wr,    // Write when high
    output logic [4:0]      cb_addr,  // Register offset
    output logic [7:0]      cb_wdata  // Write data
);
    // Bus idle from time zero
    initial begin
        cb_sel   = 1'b0;
        cb_wr    = 1'b0;
        cb_addr  = 5'h00;
        cb_wdata = 8'h00;
    end

    // One access from a falling edge; the strobe spans exactly one rising edge
    task automatic access(input logic wr, input logic [4:0] addr, input logic [7:0] data);
        cb_sel   = 1'b1;
        cb_wr    = wr;
        cb_addr  = addr;
        cb_wdata = data;
        @(negedge mclk);
        cb_sel   = 1'b0;
        cb_addr  = ~addr;  // Released lines show junk, not the last value
        cb_wdata = ~data;
        @(negedge mclk);
    endtask : access
endmodule : lsd_host

/* verification/test_lsd_timers.sv */
// Self-checking bench for the line-state duration timers
`timescale 1ns/10ps
`include "lsd_defs.svh"
module test_lsd_timers
    import lsd_pkg::*;
;
    logic                  mclk, nrst, cb_sel, cb_wr, cb_ack, tick_ref;
    logic                  noise_thr_written, state_threshold_mask, write_reject_set;
    logic                  state_threshold_event, state_threshold_int, noise_threshold_event;
    logic [4:0]            cb_addr;
    logic [7:0]            cb_wdata, cb_rdata;
    lsd_line_type          line_state;
    logic [`LSD_CNT_W-1:0] noise_threshold, st_thr;
    logic [`LSD_PRE_W-1:0] noise_prescale_threshold, sp_thr;
    logic [8:0]            exp_q[$];
    logic                  st_det, ns_det;
    logic [31:0]           seed = 32'h7CEE8801;
    int                    miscompares, check_count, cycles;
    localparam logic [4:0] ro_addr[4] = '{`LSD_ADDR_NOISE_CNT, `LSD_ADDR_NOISE_PRE,
                                          `LSD_ADDR_STATE_CNT, `LSD_ADDR_STATE_PRE};

    lsd_host u_lsd_host (.mclk(mclk), .cb_sel(cb_sel), .cb_wr(cb_wr), .cb_addr(cb_addr),
                         .cb_wdata(cb_wdata));
    // Reference tick from the constants: 50 ns steps carried modulo the symbol time,
    // restarted by the same reset so it runs in step with the divider inside
    int                    acc_ref;
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            acc_ref  <= 0;
            tick_ref <= 1'b0;
        end else if (acc_ref + `LSD_CLK_NS >= `LSD_TICK_NS) begin
            acc_ref  <= acc_ref + `LSD_CLK_NS - `LSD_TICK_NS;
            tick_ref <= 1'b1;
        end else begin
            acc_ref  <= acc_ref + `LSD_CLK_NS;
            tick_ref <= 1'b0;
        end
    end
    lsd_timers u_lsd_timers (
        .mclk(mclk), .nrst(nrst), .cb_sel(cb_sel), .cb_wr(cb_wr), .cb_addr(cb_addr),
        .cb_wdata(cb_wdata), .cb_rdata(cb_rdata), .cb_ack(cb_ack), .line_state(line_state),
        .noise_threshold(noise_threshold), .noise_prescale_threshold(noise_prescale_threshold),
        .noise_thr_written(noise_thr_written), .state_threshold_mask(state_threshold_mask),
        .write_reject_set(write_reject_set), .state_threshold_event(state_threshold_event),
        .state_threshold_int(state_threshold_int), .noise_threshold_event(noise_threshold_event));

    // Clock, 50 ns period
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Ticks from reload to zero for a prescaled pair
    function automatic int exp_ticks(input int pre, input int cnt);
        return (pre + 1) * cnt + pre;
    endfunction : exp_ticks

    task automatic cmp_rd(input logic [8:0] got, input logic [8:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_rd

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    // Note the answer {reject, data} first, then let the host make the access
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                       input logic [8:0] e);
        exp_q.push_back(e);
        u_lsd_host.access(wr, a, d);
    endtask : bus

    // Count ticks until the chosen event; called on a falling edge after the reload
    task automatic count_to(input logic noise, input int exp);
        int n;
        n = tick_ref;
        repeat (4000) begin
            @(negedge mclk);
            if ((noise ? noise_threshold_event : state_threshold_event) === 1'b1) break;
            n += tick_ref;
        end
        cmp_val(n, exp);
        if (!noise) cmp_val(state_threshold_int, !state_threshold_mask);
    endtask : count_to

    // Each acknowledge takes the oldest note; an unexpected one meets an unknown note
    always @(negedge mclk) begin
        if (cb_ack === 1'b1) cmp_rd({write_reject_set, cb_rdata},
                                    exp_q.size() > 0 ? exp_q.pop_front() : 9'bX);
    end

    // Hang guard, well above the fewer than a thousand cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        logic [31:0] r;
        nrst = 1'b0;
        line_state = LS_ACTIVE;
        noise_threshold = 7'h03;
        noise_prescale_threshold = 8'h01;
        noise_thr_written = 1'b0;
        state_threshold_mask = 1'b0;
        st_det = 1'b1;  // Reset leaves the previous state unknown, so active is a change
        ns_det = 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        nrst = 1'b1;
        // Registers while active: state pair must hold its reloaded values
        r = rnd();
        st_thr = r[6:0];
        sp_thr = r[15:8];
        bus(1'b1, `LSD_ADDR_STATE_THR, {1'b1, st_thr}, 9'h000);
        bus(1'b1, `LSD_ADDR_STATE_PRE_THR, sp_thr, 9'h000);
        bus(1'b0, `LSD_ADDR_STATE_THR, 8'h00, {2'b00, st_thr});
        bus(1'b0, `LSD_ADDR_STATE_PRE_THR, 8'h00, {1'b0, sp_thr});
        repeat (20) @(negedge mclk);
        bus(1'b0, `LSD_ADDR_STATE_CNT, 8'h00, {1'b0, st_det, st_thr});
        bus(1'b0, `LSD_ADDR_STATE_CNT, 8'h00, {2'b00, st_thr});
        bus(1'b0, `LSD_ADDR_STATE_PRE, 8'h00, {1'b0, sp_thr});
        foreach (ro_addr[i]) bus(1'b1, ro_addr[i], r[23:16], 9'h100);
        bus(1'b0, `LSD_ADDR_STATE_CNT, 8'h00, {2'b00, st_thr});
        u_lsd_host.access(1'b0, 5'h0E, 8'h00);
        u_lsd_host.access(1'b1, 5'h15, 8'hFF);
        $display("test registers done");
        // Timeout from each change into every qualifying state, then the reload after it
        for (int i = 3; i < 8; i++) begin
            r = rnd();
            st_thr = {4'h0, r[2:0] | 3'h1};
            sp_thr = {6'h00, r[9:8]};
            state_threshold_mask = r[16];
            bus(1'b1, `LSD_ADDR_STATE_THR, {1'b0, st_thr}, 9'h000);
            bus(1'b1, `LSD_ADDR_STATE_PRE_THR, sp_thr, 9'h000);
            line_state = lsd_line_type'(i);
            @(negedge mclk);
            count_to(1'b0, exp_ticks(sp_thr, st_thr));
            // Starting from both zero, the reload itself costs one tick
            count_to(1'b0, exp_ticks(sp_thr, st_thr) + 1);
        end
        ns_det = 1'b1;
        $display("test state timer done");
        // Noise pair: reloaded while qualifying, keeps counting across noise-type changes
        r = rnd();
        noise_threshold = {4'h0, r[2:0] | 3'h1};
        noise_prescale_threshold = {6'h00, r[9:8]};
        @(negedge mclk);
        bus(1'b0, `LSD_ADDR_NOISE_CNT, 8'h00, {1'b0, ns_det, noise_threshold});
        bus(1'b0, `LSD_ADDR_NOISE_CNT, 8'h00, {2'b00, noise_threshold});
        bus(1'b0, `LSD_ADDR_NOISE_PRE, 8'h00, {1'b0, noise_prescale_threshold});
        line_state = LS_NOISE;
        count_to(1'b1, exp_ticks(noise_prescale_threshold, noise_threshold));
        line_state = LS_ACTIVE;
        // Starting from both zero, the reload itself costs one tick
        count_to(1'b1, exp_ticks(noise_prescale_threshold, noise_threshold) + 1);
        noise_threshold = r[22:16];
        noise_thr_written = 1'b1;
        @(negedge mclk);
        noise_thr_written = 1'b0;
        bus(1'b0, `LSD_ADDR_NOISE_CNT, 8'h00, {2'b00, noise_threshold});
        $display("test noise timer done");
        repeat (4) @(negedge mclk);
        cmp_val(exp_q.size(), 0);
        wrap_up();
    end
endmodule : test_lsd_timers
